// *** hw/pcb_pkg.sv ***
package pcb_pkg;
    // controller clock
    localparam int CLK_MHZ = 200;
    // sequencer states
    typedef enum logic [2:0] {
        ST_BOOT = 3'h0, // waiting to launch the boot interrupt
        ST_RUN = 3'h1, // executing
        ST_IDLE = 3'h2, // plain idle
        ST_PDC = 3'h3, // core powerdown
        ST_PDCP = 3'h4, // core and peripheral powerdown
        ST_PDALL = 3'h5, // everything off, pll included
        ST_WAKE = 3'h6 // counting out the wake latency
    } pcb_state_e;
    // wake latencies in core cycles
    localparam logic [8:0] WAKE_IDLE_CYC = 9'h002;
    localparam logic [8:0] WAKE_PDC_CYC = 9'h002;
    localparam logic [8:0] WAKE_PDCP_CYC = 9'h005;
    localparam logic [8:0] PLL_RELOCK_CYC = 9'h1F4;
    // pll multiplier field
    localparam int MSEL_W = 7;
    localparam logic [6:0] MSEL_RST = 7'h00;
    localparam logic DF_RST = 1'b0;
    localparam logic BYPASS_RST = 1'b0;
    // boot rom entry point
    localparam logic [23:0] BOOT_VECTOR = 24'hFF0000;
    // boot select pin codes
    localparam logic [2:0] BOOT_RSVD0 = 3'h0;
    localparam logic [2:0] BOOT_EXT8 = 3'h1;
    localparam logic [2:0] EXEC_EXT8 = 3'h2;
    localparam logic [2:0] EXEC_EXT16 = 3'h3;
    localparam logic [2:0] BOOT_SER_SMALL = 3'h4;
    localparam logic [2:0] BOOT_SER_LARGE = 3'h5;
endpackage : pcb_pkg

// *** hw/pcb_per_clk.sv ***
`timescale 1ns/1ps
`default_nettype none
// peripheral clock enable generator, full or half core rate
module pcb_per_clk
    import pcb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic ratioHalf, // high selects half core rate
    input wire logic runEn, // low stops the peripheral clock
    output logic perTick // one enable per peripheral clock
);
    // phase of the divide-by-two
    logic phase_reg;

    // phase toggles only while running, so a restart begins on a tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= 1'b0;
        end else if (ce) begin
            if (!runEn) begin
                phase_reg <= 1'b0;
            end else begin
                phase_reg <= ~phase_reg;
            end
        end
    end

    // tick every cycle at full rate, every second cycle at half rate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perTick <= 1'b0;
        end else if (ce) begin
            perTick <= runEn && (!ratioHalf || !phase_reg);
        end
    end
endmodule : pcb_per_clk
`default_nettype wire

// *** hw/pcb_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcb_ctrl
    import pcb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic idleExec, // pulse: core executes idle
    input wire logic wakeIrq, // level: an interrupt is pending
    input wire logic powerdownSelectBit,
    input wire logic stopClockBit,
    input wire logic stallBit,
    input wire logic peripheralRatioSelect, // high: half core rate
    input wire logic pllCtlWrite, // pulse: load the fields below
    input wire logic [6:0] multiplierSelectField,
    input wire logic divideInputBit,
    input wire logic bypassPin,
    input wire logic swResetWrite, // pulse: software reset
    input wire logic irqEnable, // pulse: software unmasks interrupts
    input wire logic busRequest,
    input wire logic bootSelectBit2,
    input wire logic bootSelectBit1,
    input wire logic bootSelectBit0,
    output logic coreRun, // instruction execution allowed
    output logic coreClkEn,
    output logic periphClkEn,
    output logic clockOutputPin,
    output logic pllEnable,
    output logic pipelineRetain, // low: pipeline is flushed
    output logic lowPowerActive,
    output logic [6:0] pllMultiplier,
    output logic pllDivideInput,
    output logic pllBypass,
    output logic bootIrq, // one-cycle nonmaskable boot interrupt
    output logic [23:0] bootVector,
    output logic stackClear, // one-cycle stack pointer reset
    output logic irqMaskAll,
    output logic [2:0] bootModeCode,
    output logic bootFromExt8,
    output logic execFromExt8,
    output logic execFromExt16,
    output logic bootFromSerialSmall,
    output logic bootFromSerialLarge,
    output logic bootModeIllegal
);
    // sequencer state and its next value
    pcb_state_e state_reg;
    pcb_state_e state_next;
    // wake countdown and the mode it wakes from
    logic [8:0] wakeCnt_reg;
    logic [8:0] wakeCnt_next;
    pcb_state_e wakeFrom_reg;
    // strap capture pending after hardware reset release
    logic strapPend_reg;
    // peripheral tick from the divider
    logic perTick;
    // sleep mode a wake belongs to, already right in the cycle the wake starts
    pcb_state_e wakeFromNow;
    assign wakeFromNow = (state_reg == ST_WAKE) ? wakeFrom_reg : state_reg;

    // picks the sleep state from the three control bits
    function automatic pcb_state_e lowPowerMode(input logic pd, input logic stop_clock_bit,
                                                input logic stall);
        pcb_state_e m;
        m = ST_IDLE;
        if (pd && stop_clock_bit) begin
            m = ST_PDALL;
        end else if (pd && stall) begin
            m = ST_PDCP;
        end else if (pd) begin
            m = ST_PDC;
        end
        return m;
    endfunction : lowPowerMode

    // wake latency belonging to each sleep state
    function automatic logic [8:0] wakeLatency(input pcb_state_e s);
        logic [8:0] n;
        n = WAKE_IDLE_CYC;
        unique case (s)
            ST_PDC: n = WAKE_PDC_CYC;
            ST_PDCP: n = WAKE_PDCP_CYC;
            ST_PDALL: n = PLL_RELOCK_CYC;
            default: n = WAKE_IDLE_CYC;
        endcase
        return n;
    endfunction : wakeLatency

    // true for states in which the clock named by sel is stopped
    function automatic logic clockStopped(input pcb_state_e s, input pcb_state_e from,
                                          input logic [1:0] sel);
        logic stopped;
        pcb_state_e eff;
        eff = (s == ST_WAKE) ? from : s;
        stopped = 1'b0;
        unique case (sel)
            2'h0: stopped = (eff == ST_PDC) || (eff == ST_PDCP) || (eff == ST_PDALL);
            2'h1: stopped = (eff == ST_PDCP) || (eff == ST_PDALL);
            default: stopped = (eff == ST_PDALL);
        endcase
        // the core clock restarts as soon as the wake count begins, except after full powerdown
        if (s == ST_WAKE && sel == 2'h0 && from != ST_PDALL) begin
            stopped = 1'b0;
        end
        // the pll must run through its relock wait or it can never settle
        if (s == ST_WAKE && sel == 2'h2) begin
            stopped = 1'b0;
        end
        return stopped;
    endfunction : clockStopped

    // sequencer next state; the count of a wake starts at latency minus one
    always_comb begin
        state_next = state_reg;
        wakeCnt_next = wakeCnt_reg;
        if (swResetWrite) begin
            state_next = ST_BOOT;
        end else begin
            unique case (state_reg)
                ST_BOOT: begin
                    // hold until the bus is released
                    if (!busRequest) begin
                        state_next = ST_RUN;
                    end
                end
                ST_RUN: begin
                    // sleep is only ever entered by the idle instruction
                    if (idleExec) begin
                        state_next = lowPowerMode(powerdownSelectBit, stopClockBit,
                                                  stallBit);
                    end
                end
                ST_IDLE, ST_PDC, ST_PDCP, ST_PDALL: begin
                    if (wakeIrq) begin
                        state_next = ST_WAKE;
                        wakeCnt_next = wakeLatency(state_reg) - 9'h001;
                    end
                end
                ST_WAKE: begin
                    if (wakeCnt_reg == 9'h000) begin
                        state_next = ST_RUN;
                    end else begin
                        wakeCnt_next = wakeCnt_reg - 9'h001;
                    end
                end
                default: begin
                    state_next = ST_BOOT;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_BOOT;
            wakeCnt_reg <= 9'h000;
        end else if (ce) begin
            state_reg <= state_next;
            wakeCnt_reg <= wakeCnt_next;
        end
    end

    // remember which sleep mode the wake belongs to
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeFrom_reg <= ST_IDLE;
        end else if (ce) begin
            if (state_next == ST_WAKE && state_reg != ST_WAKE) begin
                wakeFrom_reg <= state_reg;
            end
        end
    end

    // clock gates follow the next state so they line up with state_reg
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coreClkEn <= 1'b1;
            pllEnable <= 1'b1;
        end else if (ce) begin
            // idle keeps the core clock, the powerdowns do not
            // the stored mode is one cycle late at wake start, so use the live one
            coreClkEn <= !clockStopped(state_next, wakeFromNow, 2'h0);
            // pll is off in full powerdown and back on when its relock wait begins
            pllEnable <= !clockStopped(state_next, wakeFromNow, 2'h2);
        end
    end

    // instruction execution and pipeline retention
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coreRun <= 1'b0;
            pipelineRetain <= 1'b0;
            lowPowerActive <= 1'b0;
        end else if (ce) begin
            coreRun <= (state_next == ST_RUN);
            lowPowerActive <= (state_next != ST_RUN) && (state_next != ST_BOOT);
            // deep modes lose the pipeline; it stays lost until the next run
            if (state_next == ST_PDCP || state_next == ST_PDALL || state_next == ST_BOOT) begin
                pipelineRetain <= 1'b0;
            end else if (state_next == ST_IDLE || state_next == ST_PDC) begin
                pipelineRetain <= 1'b1;
            end else if (state_next == ST_RUN) begin
                pipelineRetain <= 1'b1;
            end
        end
    end

    // peripheral clock stops in the two deepest modes
    pcb_per_clk u_perClk (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .ratioHalf(peripheralRatioSelect),
        .runEn(!clockStopped(state_reg, wakeFrom_reg, 2'h1)),
        .perTick(perTick)
    );

    // peripheral clock out on the pin, one register stage after the divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periphClkEn <= 1'b0;
            clockOutputPin <= 1'b0;
        end else if (ce) begin
            periphClkEn <= perTick;
            clockOutputPin <= perTick;
        end
    end

    // strap capture: constant under reset, pins caught on the first edge after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strapPend_reg <= 1'b1;
        end else if (ce) begin
            strapPend_reg <= 1'b0;
        end
    end

    // pll multiplier: defaults under reset, strap after release, then software
    // a divide bit set wrongly for the input rate is software's fault
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pllMultiplier <= MSEL_RST;
            pllDivideInput <= DF_RST;
            pllBypass <= BYPASS_RST;
        end else if (ce) begin
            if (strapPend_reg) begin
                pllMultiplier <= multiplierSelectField;
                pllDivideInput <= divideInputBit;
                pllBypass <= bypassPin;
            end else if (pllCtlWrite) begin
                pllMultiplier <= multiplierSelectField;
                pllDivideInput <= divideInputBit;
                pllBypass <= bypassPin;
            end
        end
    end

    // boot pins are held only from a hardware reset, not a software one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bootModeCode <= BOOT_RSVD0;
        end else if (ce) begin
            if (strapPend_reg) begin
                bootModeCode <= {bootSelectBit2, bootSelectBit1, bootSelectBit0};
            end
        end
    end

    // boot source decode from the held code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bootFromExt8 <= 1'b0;
            execFromExt8 <= 1'b0;
            execFromExt16 <= 1'b0;
            bootFromSerialSmall <= 1'b0;
            bootFromSerialLarge <= 1'b0;
            bootModeIllegal <= 1'b0;
        end else if (ce) begin
            bootFromExt8 <= (bootModeCode == BOOT_EXT8);
            execFromExt8 <= (bootModeCode == EXEC_EXT8);
            execFromExt16 <= (bootModeCode == EXEC_EXT16);
            bootFromSerialSmall <= (bootModeCode == BOOT_SER_SMALL);
            bootFromSerialLarge <= (bootModeCode == BOOT_SER_LARGE);
            // 000, 110 and 111 leave every source line low
            bootModeIllegal <= (bootModeCode == BOOT_RSVD0) ||
                               (bootModeCode > BOOT_SER_LARGE);
        end
    end

    // boot interrupt pulses on leaving the boot state; vector is fixed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bootIrq <= 1'b0;
            bootVector <= BOOT_VECTOR;
        end else if (ce) begin
            bootIrq <= (state_reg == ST_BOOT) && (state_next == ST_RUN);
            bootVector <= BOOT_VECTOR;
        end
    end

    // stacks emptied and interrupts masked by either kind of reset
    // the reset source must outlast pll lock; nothing here times it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stackClear <= 1'b1;
            irqMaskAll <= 1'b1;
        end else if (ce) begin
            stackClear <= swResetWrite;
            // a software reset wins over an unmask in the same cycle
            if (swResetWrite) begin
                irqMaskAll <= 1'b1;
            end else if (irqEnable) begin
                irqMaskAll <= 1'b0;
            end
        end
    end

    // clock limits are software's concern; no check is made
endmodule : pcb_ctrl
`default_nettype wire

// *** sim/pcb_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the power, clock and boot sequencer
module pcb_ctrl_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic idleExec,
    input wire logic wakeIrq,
    input wire logic powerdownSelectBit,
    input wire logic stopClockBit,
    input wire logic stallBit,
    input wire logic peripheralRatioSelect,
    input wire logic pllCtlWrite,
    input wire logic [6:0] multiplierSelectField,
    input wire logic swResetWrite,
    input wire logic busRequest,
    input wire logic coreRun,
    input wire logic coreClkEn,
    input wire logic periphClkEn,
    input wire logic clockOutputPin,
    input wire logic pllEnable,
    input wire logic pipelineRetain,
    input wire logic [6:0] pllMultiplier,
    input wire logic bootIrq,
    input wire logic [23:0] bootVector,
    input wire logic stackClear,
    input wire logic irqMaskAll,
    input wire logic [2:0] bootModeCode,
    input wire logic bootFromExt8,
    input wire logic bootModeIllegal
);
    logic sleepReg; // asleep or counting out a wake
    logic [1:0] modeReg; // mode taken at idle entry
    logic wakePrev; // wake request one cycle back
    logic wkStart; // first wake request seen in sleep
    logic enter; // idle accepted this cycle
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign enter = idleExec && coreRun;
    assign wkStart = sleepReg && wakeIrq && !wakePrev;
    // sleep flag, dropped on run so it never leaks into the next entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sleepReg <= 1'b0;
        else if (enter) sleepReg <= 1'b1;
        else if (coreRun || swResetWrite) sleepReg <= 1'b0;
    end
    // mode picked from the select bits at entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) modeReg <= 2'h0;
        else if (enter) modeReg <= !powerdownSelectBit ? 2'h0 :
            stopClockBit ? 2'h3 : stallBit ? 2'h2 : 2'h1;
    end
    // edge finder for the wake request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) wakePrev <= 1'b0;
        else wakePrev <= wakeIrq;
    end
    AST_ENTRY: assert property ($fell(coreRun) |->
        $past(idleExec) || $past(swResetWrite))
        else $error("core halted without idle or soft reset");
    AST_IDLE_CLK: assert property (sleepReg && modeReg == 2'h0 |->
        coreClkEn && pllEnable && pipelineRetain)
        else $error("idle mode stopped a clock");
    AST_WAKE_SHORT: assert property (wkStart && !modeReg[1] |->
        ##1 !coreRun [*2] ##1 coreRun)
        else $error("short wake latency wrong");
    AST_PDC: assert property (enter && powerdownSelectBit &&
        !stopClockBit && !stallBit |=> !coreClkEn && pllEnable && pipelineRetain)
        else $error("core powerdown clocks wrong");
    // the peripheral tick passes two flops, so it goes quiet two cycles later
    AST_PDCP: assert property (enter && powerdownSelectBit &&
        !stopClockBit && stallBit |=> !coreClkEn && pllEnable && !pipelineRetain
        ##2 !periphClkEn [*3])
        else $error("core and peripheral powerdown clocks wrong");
    AST_WAKE_PDCP: assert property (wkStart && modeReg == 2'h2 |->
        ##1 !coreRun [*5] ##1 coreRun)
        else $error("five cycle wake latency wrong");
    AST_PDALL: assert property (enter && powerdownSelectBit && stopClockBit |=>
        !pllEnable && !coreClkEn && !pipelineRetain ##2 !periphClkEn [*3])
        else $error("full powerdown left something running");
    AST_WAKE_ALL: assert property (wkStart && modeReg == 2'h3 |->
        ##[500:500] !coreRun ##1 coreRun)
        else $error("relock wait wrong");
    AST_RELOCK: assert property (wkStart && modeReg == 2'h3 |=> pllEnable && !coreClkEn)
        else $error("pll not running or core clock early in relock wait");
    AST_PLL: assert property (pllCtlWrite |=>
        pllMultiplier == $past(multiplierSelectField))
        else $error("multiplier not loaded");
    AST_HALF: assert property ((coreRun && peripheralRatioSelect) [*6] ##0 periphClkEn |=>
        !periphClkEn)
        else $error("half rate tick repeated");
    AST_CLOCK_OUTPUT_PIN: assert property (clockOutputPin == periphClkEn)
        else $error("clock output differs from peripheral clock");
    AST_BUSHOLD: assert property (!coreRun && !sleepReg && busRequest |=>
        !coreRun && !bootIrq)
        else $error("boot started under bus request");
    AST_BOOT: assert property (bootIrq |-> $rose(coreRun) && bootVector == 24'hFF0000)
        else $error("boot interrupt out of place");
    AST_SWRST: assert property (swResetWrite |=>
        stackClear && irqMaskAll && !coreRun ##1 !stackClear)
        else $error("soft reset effects wrong");
    AST_DECODE: assert property ($past(coreRun) && coreRun |->
        bootFromExt8 == (bootModeCode == 3'h1)
        && bootModeIllegal == (bootModeCode == 3'h0 || bootModeCode[2:1] == 2'h3))
        else $error("boot code decode wrong");
    // main scenarios reached
    COV_ALL: cover property (wkStart && modeReg == 2'h3);
    COV_PDCP: cover property (wkStart && modeReg == 2'h2);
    COV_SWRST: cover property (swResetWrite ##2 bootIrq);
endmodule : pcb_ctrl_asserts
bind pcb_ctrl pcb_ctrl_asserts chk_u (.clk, .rst_n, .idleExec, .wakeIrq, .powerdownSelectBit,
    .stopClockBit, .stallBit, .peripheralRatioSelect, .pllCtlWrite, .multiplierSelectField,
    .swResetWrite, .busRequest, .coreRun, .coreClkEn, .periphClkEn, .clockOutputPin, .pllEnable,
    .pipelineRetain, .pllMultiplier, .bootIrq, .bootVector, .stackClear, .irqMaskAll,
    .bootModeCode, .bootFromExt8, .bootModeIllegal);
`default_nettype wire

// *** sim/pcb_boot_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// boot memory side: strap pins and a bus request that lingers after reset
module pcb_boot_mem (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] code, // strap pattern to present
    input wire logic [1:0] holdCyc, // cycles the request outlives reset
    output logic bootSelectBit2,
    output logic bootSelectBit1,
    output logic bootSelectBit0,
    output logic busRequest
);
    logic [1:0] holdReg; // request cycles left
    // straps are driven solidly, so they are valid through reset
    assign {bootSelectBit2, bootSelectBit1, bootSelectBit0} = code;
    // countdown lets a slow memory hold off boot
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) holdReg <= holdCyc;
        else if (holdReg != 2'h0) holdReg <= holdReg - 2'h1;
    end
    assign busRequest = !rst_n || holdReg != 2'h0;
endmodule : pcb_boot_mem
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst_n, ce, idleExec, wakeIrq, powerdownSelectBit, stopClockBit, stallBit;
    logic peripheralRatioSelect, pllCtlWrite, divideInputBit, bypassPin, swResetWrite;
    logic irqEnable, busRequest, bootSelectBit2, bootSelectBit1, bootSelectBit0;
    logic [6:0] multiplierSelectField, pllMultiplier;
    logic coreRun, coreClkEn, periphClkEn, clockOutputPin, pllEnable, pipelineRetain;
    logic lowPowerActive, pllDivideInput, pllBypass, bootIrq, stackClear, irqMaskAll;
    logic bootFromExt8, execFromExt8, execFromExt16, bootFromSerialSmall;
    logic bootFromSerialLarge, bootModeIllegal;
    logic [23:0] bootVector;
    logic [2:0] bootModeCode, code, oldCode;
    logic [1:0] hold; // partner request holdoff
    logic [31:0] seed; // random source state
    int nMismatch, checked, cyc, n;
    pcb_ctrl dut_u (.clk, .rst_n, .ce, .idleExec, .wakeIrq, .powerdownSelectBit, .stopClockBit,
        .stallBit, .peripheralRatioSelect, .pllCtlWrite, .multiplierSelectField, .divideInputBit,
        .bypassPin, .swResetWrite, .irqEnable, .busRequest, .bootSelectBit2, .bootSelectBit1,
        .bootSelectBit0, .coreRun, .coreClkEn, .periphClkEn, .clockOutputPin, .pllEnable,
        .pipelineRetain, .lowPowerActive, .pllMultiplier, .pllDivideInput, .pllBypass, .bootIrq,
        .bootVector, .stackClear, .irqMaskAll, .bootModeCode, .bootFromExt8, .execFromExt8,
        .execFromExt16, .bootFromSerialSmall, .bootFromSerialLarge, .bootModeIllegal);
    pcb_boot_mem mem_u (.clk, .rst_n, .code, .holdCyc(hold), .bootSelectBit2, .bootSelectBit1,
        .bootSelectBit0, .busRequest);
    // free running 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard; the whole run needs well under this
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            nMismatch++;
            summarize();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // one-hot source flags expected for a strap code
    function automatic logic [5:0] dec(input logic [2:0] c);
        case (c)
            3'h1: return 6'h20;
            3'h2: return 6'h10;
            3'h3: return 6'h08;
            3'h4: return 6'h04;
            3'h5: return 6'h02;
            default: return 6'h01; // reserved patterns select nothing
        endcase
    endfunction : dec
    // inputs move a fixed 1 ns after the edge, outputs are settled then
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            nMismatch++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("counts: %0d checks, %0d mismatches", checked, nMismatch);
        if (nMismatch == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    // count edges until the core runs again, bounded
    task automatic wait_run();
        n = 0;
        while (coreRun !== 1'b1 && n < 600) begin
            step();
            n++;
        end
    endtask : wait_run
    // enter mode m, look at the clocks, then wake and time it
    task automatic sleep_wake(input int m);
        logic [2:0] clkExp[4] = '{3'h7, 3'h3, 3'h2, 3'h0};
        int lat[4] = '{2, 2, 5, 500};
        seed = lfsr(seed);
        peripheralRatioSelect = seed[0];
        powerdownSelectBit = (m != 0);
        stopClockBit = (m == 3) || (m == 0 && seed[1]); // unused bits random when idle
        stallBit = (m == 2) || (m != 1 && seed[2]);
        idleExec = 1'b1;
        step();
        idleExec = 1'b0;
        chk(coreRun, 1'b0);
        repeat (4) step();
        chk({coreClkEn, pllEnable, pipelineRetain}, clkExp[m]);
        chk(lowPowerActive, 1'b1);
        if (m > 1) chk(periphClkEn, 1'b0);
        wakeIrq = 1'b1;
        step();
        wait_run();
        wakeIrq = 1'b0;
        chk(n, lat[m]);
        chk(lowPowerActive, 1'b0);
    endtask : sleep_wake
    initial begin
        {rst_n, idleExec, wakeIrq, powerdownSelectBit, stopClockBit, stallBit} = '0;
        {peripheralRatioSelect, pllCtlWrite, divideInputBit, bypassPin} = '0;
        {swResetWrite, irqEnable, multiplierSelectField, code, hold} = '0;
        ce = 1'b1;
        seed = 32'hB1D8;
        // every strap code, random straps and bus holdoff
        for (int c = 0; c < 8; c++) begin
            seed = lfsr(seed);
            code = c[2:0];
            hold = seed[1:0];
            {bypassPin, divideInputBit, multiplierSelectField} = seed[10:2];
            rst_n = 1'b0;
            // no pll is modelled here, so a short hold stands in for lock time
            repeat (5) step();
            chk({stackClear, irqMaskAll, coreRun}, 3'h6);
            rst_n = 1'b1;
            wait_run();
            chk(n, hold + 1);
            chk({bootIrq, bootVector}, 25'h1FF0000);
            chk({pllBypass, pllDivideInput, pllMultiplier}, seed[10:2]);
            step();
            chk(bootModeCode, code);
            chk({bootFromExt8, execFromExt8, execFromExt16, bootFromSerialSmall,
                bootFromSerialLarge, bootModeIllegal}, dec(code));
        end
        $display("test boot done");
        for (int m = 0; m < 8; m++) sleep_wake(m % 4);
        $display("test lowpower done");
        // write strobe held high across back-to-back loads
        pllCtlWrite = 1'b1;
        repeat (4) begin
            seed = lfsr(seed);
            {bypassPin, divideInputBit, multiplierSelectField} = seed[8:0];
            step();
            chk({pllBypass, pllDivideInput, pllMultiplier}, seed[8:0]);
        end
        pllCtlWrite = 1'b0;
        $display("test pll done");
        for (int r = 0; r < 2; r++) begin
            peripheralRatioSelect = r[0];
            repeat (8) step();
            n = 0;
            repeat (8) begin
                step();
                if (periphClkEn === 1'b1) n++;
            end
            chk(n, r ? 4 : 8);
        end
        $display("test ratio done");
        irqEnable = 1'b1;
        step();
        irqEnable = 1'b0;
        chk(irqMaskAll, 1'b0);
        oldCode = code;
        code = ~code;
        swResetWrite = 1'b1;
        step();
        swResetWrite = 1'b0;
        chk({stackClear, irqMaskAll, coreRun}, 3'h6);
        step();
        chk({coreRun, bootIrq, stackClear}, 3'h6);
        chk(bootModeCode, oldCode);
        $display("test softreset done");
        summarize();
    end
endmodule : tb
`default_nettype wire
